// ==== inc/aus_regs.svh ====
// register map, field positions and timing counts of the async serial port
//
// Notes on behaviour
// R1 - async operation needs synchronous-select clear and port enable set.
// R2 - in nine-bit transmit a set ninth bit marks an address character.
// R3 - transmit polarity set inverts the whole transmit stream, idle included.
// R4 - setting transmitter enable raises buffer-empty flag when holding buffer empty.
// R5 - transmit interrupt when its enable, peripheral and global enables and flag set.
// R6 - load ninth bit first; writing transmit data starts the character.
// R7 - receive line oversampled sixteen times per bit; shift register steps per bit.
// R8 - finished character moves at once into a two-entry receive fifo.
// R9 - receiver runs only with receive enable, port enable and async selected.
// R10 - software sets receive pin as digital input and clears its analog select.
// R11 - a character starts on a falling edge while hunting for a start bit.
// R12 - start still high at half bit: drop silently, hunt again.
// R13 - each data bit taken at bit centre by majority vote, shifted in.
// R14 - stop position low sets framing error for that character, high clears it.
// R15 - after stop sample the character is pushed and data-available flag set.
// R16 - reading receive data returns oldest character and removes it.
// R17 - while overrun stands no further characters are accepted.
// R18 - data-available flag is read-only, high when enabled and data buffered.
// R19 - receive interrupt only with its enable, peripheral and global enables set.
// R20 - framing status kept per character; the oldest one is shown.
// R21 - framing status read-only, never blocks reception, follows fifo reads.
// R22 - port enable clear forces framing status clear; receive enable clear keeps it.
// R23 - lsb first, one low start bit, high stop bit, idle line high.
// R24 - third character with two unread sets overrun; cleared by either enable.
// R25 - received ninth bit shown for the oldest unread character.
// R26 - oversampling tick from divisor pair and two rate-select bits.
`ifndef AUS_REGS_SVH
`define AUS_REGS_SVH

`define AUS_ADDR_BAUD_CTL  4'h0
`define AUS_ADDR_RX_CTL    4'h1
`define AUS_ADDR_BRG_LO    4'h2
`define AUS_ADDR_BRG_HI    4'h3
`define AUS_ADDR_TX_DATA   4'h4
`define AUS_ADDR_TX_CTL    4'h5
`define AUS_ADDR_RX_DATA   4'h6
`define AUS_ADDR_INT_FLAG  4'h7
`define AUS_ADDR_INT_EN    4'h8
`define AUS_ADDR_CORE_INT  4'h9

`define AUS_TX_NINE        6
`define AUS_TX_EN          5
`define AUS_TX_SYNC        4
`define AUS_TX_HIGH_RATE   2
`define AUS_TX_EMPTY       1
`define AUS_TX_NINTH       0
`define AUS_TX_WMASK       8'hfd

`define AUS_RC_PORT_EN     7
`define AUS_RC_NINE        6
`define AUS_RC_CONT_EN     4
`define AUS_RC_ADDR_DET    3
`define AUS_RC_WMASK       8'hf8

`define AUS_BC_RX_IDLE     6
`define AUS_BC_POLARITY    4
`define AUS_BC_WIDE        3
`define AUS_BC_WMASK       8'h1b

`define AUS_INT_RX         5
`define AUS_INT_TX         4
`define AUS_CI_GLOBAL      7
`define AUS_CI_PERIPH      6

`define AUS_TX_CTL_RESET   8'h02
`define AUS_ZERO_RESET     8'h00

`define AUS_OS_LAST        4'hf
`define AUS_OS_HALF        4'h7
`define AUS_OS_VOTE        4'hd
`define AUS_BITS_8         4'h8
`define AUS_BITS_9         4'h9
`define AUS_FRAME_8        4'ha
`define AUS_FRAME_9        4'hb
`define AUS_PRE_SLOW       2'h3
`define AUS_PRE_FAST       2'h0
`define AUS_FIFO_FULL      2'h2

`endif

// ==== inc/aus_pkg.sv ====
// types shared by the async serial port design
package aus_pkg;
	typedef enum logic [1:0] {
		AUS_RX_HUNT,
		AUS_RX_START,
		AUS_RX_DATA,
		AUS_RX_STOP
	} aus_rx_state_t;
	typedef logic [7:0] aus_byte_t;
endpackage : aus_pkg

// ==== rtl/aus_baud_gen.sv ====
// oversampling tick divider
`timescale 1ns/1ps
`default_nettype none
`include "aus_regs.svh"
module aus_baud_gen
	import aus_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        run,
	input  wire logic [15:0] divisor,
	input  wire logic        wide,
	input  wire logic        high_rate,
	output var  logic        tick
);
	logic [15:0] cnt_reg;
	logic [1:0]  pre_reg;
	logic [15:0] reload;
	logic [1:0]  pre_last;

	assign reload   = wide ? divisor : {8'h00, divisor[7:0]};
	assign pre_last = (!wide && !high_rate) ? `AUS_PRE_SLOW : `AUS_PRE_FAST;

	// R26 divisor and prescale
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 16'h0000;
			pre_reg <= 2'h0;
			tick    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= 16'h0000;
			pre_reg <= 2'h0;
			tick    <= 1'b0;
		end else if (cnt_reg == 16'h0000) begin
			cnt_reg <= reload;
			tick    <= (pre_reg >= pre_last);
			pre_reg <= (pre_reg >= pre_last) ? 2'h0 : pre_reg + 2'h1;
		end else begin
			cnt_reg <= cnt_reg - 16'h0001;
			tick    <= 1'b0;
		end
	end
endmodule : aus_baud_gen
`default_nettype wire

// ==== rtl/aus_core.sv ====
// async serial port: register file, transmitter, receiver and receive fifo
`timescale 1ns/1ps
`default_nettype none
`include "aus_regs.svh"
module aus_core
	import aus_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	input  wire logic       receive_line_pin,
	output var  logic       tx_pin_out,
	output var  logic       tx_pin_oe,
	output var  logic       tx_irq,
	output var  logic       rx_irq
);
	////////////////////////////////////////////////////////////////////////////////
	// control registers
	aus_byte_t baud_control_reg;
	aus_byte_t receive_status_control_reg;
	aus_byte_t baud_divisor_low_reg;
	aus_byte_t baud_divisor_high_reg;
	aus_byte_t transmit_status_control_reg;
	aus_byte_t peripheral_interrupt_enable_reg;
	aus_byte_t core_interrupt_control_reg;

	logic port_enable;
	logic sync_select;
	logic async_on;
	logic tx_on;
	logic rx_on;
	logic tick;

	// R1 async select
	assign port_enable = receive_status_control_reg[`AUS_RC_PORT_EN];
	assign sync_select = transmit_status_control_reg[`AUS_TX_SYNC];
	assign async_on    = port_enable & ~sync_select;
	assign tx_on       = async_on & transmit_status_control_reg[`AUS_TX_EN];
	// R9 receiver gating
	assign rx_on       = async_on & receive_status_control_reg[`AUS_RC_CONT_EN];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			baud_control_reg                <= `AUS_ZERO_RESET;
			receive_status_control_reg      <= `AUS_ZERO_RESET;
			baud_divisor_low_reg            <= `AUS_ZERO_RESET;
			baud_divisor_high_reg           <= `AUS_ZERO_RESET;
			transmit_status_control_reg     <= `AUS_ZERO_RESET;
			peripheral_interrupt_enable_reg <= `AUS_ZERO_RESET;
			core_interrupt_control_reg      <= `AUS_ZERO_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`AUS_ADDR_BAUD_CTL: baud_control_reg <= reg_wdata & `AUS_BC_WMASK;
				`AUS_ADDR_RX_CTL:   receive_status_control_reg <= reg_wdata & `AUS_RC_WMASK;
				`AUS_ADDR_BRG_LO:   baud_divisor_low_reg <= reg_wdata;
				`AUS_ADDR_BRG_HI:   baud_divisor_high_reg <= reg_wdata;
				`AUS_ADDR_TX_CTL:   transmit_status_control_reg <= reg_wdata & `AUS_TX_WMASK;
				`AUS_ADDR_INT_EN:   peripheral_interrupt_enable_reg <= reg_wdata;
				`AUS_ADDR_CORE_INT: core_interrupt_control_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// oversampling tick
	aus_baud_gen u_baud (
		.clk       (clk),
		.arst_n    (arst_n),
		.run       (async_on),
		.divisor   ({baud_divisor_high_reg, baud_divisor_low_reg}),
		.wide      (baud_control_reg[`AUS_BC_WIDE]),
		.high_rate (transmit_status_control_reg[`AUS_TX_HIGH_RATE]),
		.tick      (tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transmit holding buffer
	logic      hold_full_reg;
	aus_byte_t hold_data_reg;
	logic      hold_ninth_reg;
	logic      tx_busy_reg;
	logic      tx_load;
	logic      tx_data_wr;
	logic      tx_empty_flag;

	assign tx_data_wr = reg_wr && (reg_addr == `AUS_ADDR_TX_DATA) && tx_on;
	assign tx_load    = tx_on & hold_full_reg & ~tx_busy_reg;

	// R6 ninth bit latched with data write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hold_full_reg  <= 1'b0;
			hold_data_reg  <= `AUS_ZERO_RESET;
			hold_ninth_reg <= 1'b0;
		end else if (!tx_on) begin
			hold_full_reg  <= 1'b0;
		end else if (tx_data_wr) begin
			hold_full_reg  <= 1'b1;
			hold_data_reg  <= reg_wdata;
			hold_ninth_reg <= transmit_status_control_reg[`AUS_TX_NINTH];
		end else if (tx_load) begin
			hold_full_reg  <= 1'b0;
		end
	end

	// R4 empty flag follows enable
	assign tx_empty_flag = tx_on & ~hold_full_reg;

	////////////////////////////////////////////////////////////////////////////////
	// transmit shifter
	logic [10:0] tx_shift_reg;
	logic [3:0]  tx_left_reg;
	logic [3:0]  tx_os_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_busy_reg  <= 1'b0;
			tx_shift_reg <= 11'h7ff;
			tx_left_reg  <= 4'h0;
			tx_os_reg    <= 4'h0;
		end else if (!tx_on) begin
			tx_busy_reg  <= 1'b0;
			tx_shift_reg <= 11'h7ff;
			tx_os_reg    <= 4'h0;
		end else if (tx_load) begin
			tx_busy_reg <= 1'b1;
			tx_os_reg   <= 4'h0;
			// R2 ninth bit as address mark
			// R23 start low, lsb first, stop high
			if (transmit_status_control_reg[`AUS_TX_NINE]) begin
				tx_shift_reg <= {1'b1, hold_ninth_reg, hold_data_reg, 1'b0};
				tx_left_reg  <= `AUS_FRAME_9;
			end else begin
				tx_shift_reg <= {2'b11, hold_data_reg, 1'b0};
				tx_left_reg  <= `AUS_FRAME_8;
			end
		end else if (tx_busy_reg && tick) begin
			tx_os_reg <= tx_os_reg + 4'h1;
			if (tx_os_reg == `AUS_OS_LAST) begin
				tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
				tx_left_reg  <= tx_left_reg - 4'h1;
				if (tx_left_reg == 4'h1) begin
					tx_busy_reg <= 1'b0;
				end
			end
		end
	end

	// R3 polarity inverts line and idle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_pin_out <= 1'b1;
			tx_pin_oe  <= 1'b0;
		end else begin
			tx_pin_out <= (tx_busy_reg ? tx_shift_reg[0] : 1'b1)
				^ baud_control_reg[`AUS_BC_POLARITY];
			tx_pin_oe  <= async_on;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive line synchroniser
	logic rx_meta_reg;
	logic rx_sync_reg;
	logic rx_prev_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_meta_reg <= 1'b1;
			rx_sync_reg <= 1'b1;
			rx_prev_reg <= 1'b1;
		end else begin
			rx_meta_reg <= receive_line_pin;
			rx_sync_reg <= rx_meta_reg;
			rx_prev_reg <= rx_sync_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive data recovery
	aus_rx_state_t rx_state_reg;
	logic [3:0]    rx_os_reg;
	logic [3:0]    rx_left_reg;
	logic [1:0]    rx_vote_reg;
	logic [8:0]    rsr_reg;
	logic          rx_framing_error_status_reg;
	logic          rx_done_reg;
	logic          overrun_reg;
	logic          vote;
	logic          rx_nine;

	assign rx_nine = receive_status_control_reg[`AUS_RC_NINE];
	// R13 two-of-three majority
	assign vote = (rx_vote_reg[1] & rx_vote_reg[0]) | (rx_vote_reg[1] & rx_sync_reg)
		| (rx_vote_reg[0] & rx_sync_reg);

	// R7 sixteen ticks per bit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_vote_reg <= 2'b11;
		end else if (tick && rx_os_reg >= `AUS_OS_VOTE) begin
			rx_vote_reg <= {rx_vote_reg[0], rx_sync_reg};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_state_reg <= AUS_RX_HUNT;
			rx_os_reg    <= 4'h0;
			rx_left_reg  <= 4'h0;
			rsr_reg      <= 9'h000;
			rx_framing_error_status_reg  <= 1'b0;
			rx_done_reg  <= 1'b0;
		end else if (!rx_on) begin
			rx_state_reg <= AUS_RX_HUNT;
			rx_os_reg    <= 4'h0;
			rx_done_reg  <= 1'b0;
		end else begin
			rx_done_reg <= 1'b0;
			unique case (rx_state_reg)
				AUS_RX_HUNT: begin
					// R11 falling edge starts
					// R17 no start while overrun
					if (!overrun_reg && rx_prev_reg && !rx_sync_reg) begin
						rx_state_reg <= AUS_RX_START;
						rx_os_reg    <= 4'h0;
					end
				end
				AUS_RX_START: begin
					if (tick) begin
						rx_os_reg <= rx_os_reg + 4'h1;
						// R12 half-bit start check
						if (rx_os_reg == `AUS_OS_HALF) begin
							rx_os_reg <= 4'h0;
							if (!rx_sync_reg) begin
								rx_state_reg <= AUS_RX_DATA;
								rx_left_reg  <= rx_nine ? `AUS_BITS_9 : `AUS_BITS_8;
							end else begin
								rx_state_reg <= AUS_RX_HUNT;
							end
						end
					end
				end
				AUS_RX_DATA: begin
					if (tick) begin
						rx_os_reg <= rx_os_reg + 4'h1;
						// R13 shift voted bit
						if (rx_os_reg == `AUS_OS_LAST) begin
							rsr_reg     <= {vote, rsr_reg[8:1]};
							rx_left_reg <= rx_left_reg - 4'h1;
							if (rx_left_reg == 4'h1) begin
								rx_state_reg <= AUS_RX_STOP;
							end
						end
					end
				end
				AUS_RX_STOP: begin
					if (tick) begin
						rx_os_reg <= rx_os_reg + 4'h1;
						// R14 stop sample sets framing
						if (rx_os_reg == `AUS_OS_LAST) begin
							rx_framing_error_status_reg  <= ~vote;
							rx_done_reg  <= 1'b1;
							rx_state_reg <= AUS_RX_HUNT;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive fifo
	aus_byte_t  fifo_data[2];
	logic [1:0] fifo_ninth;
	logic [1:0] fifo_framing_error_status;
	logic       wr_ptr_reg;
	logic       rd_ptr_reg;
	logic [1:0] count_reg;
	logic       accept;
	logic       push;
	logic       pop;
	aus_byte_t  rx_char;
	logic       rx_char_ninth;
	logic       rx_avail_flag;
	logic       top_framing_error_status;
	logic       top_ninth;

	assign rx_char       = rx_nine ? rsr_reg[7:0] : rsr_reg[8:1];
	assign rx_char_ninth = rx_nine & rsr_reg[8];
	assign accept        = rx_done_reg && !(receive_status_control_reg[`AUS_RC_ADDR_DET]
		&& rx_nine && !rx_char_ninth);
	// R16 read pops oldest
	assign pop  = reg_rd && (reg_addr == `AUS_ADDR_RX_DATA) && (count_reg != 2'h0);
	// R8 R15 push on completion
	assign push = accept && ((count_reg != `AUS_FIFO_FULL) || pop);

	generate
		for (genvar i = 0; i < 2; i++) begin : g_entry
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					fifo_data[i]  <= `AUS_ZERO_RESET;
					fifo_ninth[i] <= 1'b0;
					fifo_framing_error_status[i]  <= 1'b0;
				end else if (push && wr_ptr_reg == 1'(i)) begin
					fifo_data[i]  <= rx_char;
					fifo_ninth[i] <= rx_char_ninth;
					// R20 framing stored per entry
					fifo_framing_error_status[i]  <= rx_framing_error_status_reg;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else if (!port_enable) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// R24 overrun set and clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			overrun_reg <= 1'b0;
		end else if (accept && count_reg == `AUS_FIFO_FULL && !pop) begin
			overrun_reg <= 1'b1;
		end else if (!rx_on) begin
			overrun_reg <= 1'b0;
		end
	end

	// R21 R22 framing follows top entry
	assign top_framing_error_status  = (count_reg != 2'h0) & fifo_framing_error_status[rd_ptr_reg];
	// R25 ninth bit of top entry
	assign top_ninth = (count_reg != 2'h0) & fifo_ninth[rd_ptr_reg];
	// R18 level flag
	assign rx_avail_flag = rx_on & (count_reg != 2'h0);

	////////////////////////////////////////////////////////////////////////////////
	// interrupt requests
	logic irq_gate;

	assign irq_gate = core_interrupt_control_reg[`AUS_CI_GLOBAL]
		& core_interrupt_control_reg[`AUS_CI_PERIPH];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_irq <= 1'b0;
			rx_irq <= 1'b0;
		end else begin
			// R5 transmit request
			tx_irq <= irq_gate & peripheral_interrupt_enable_reg[`AUS_INT_TX] & tx_empty_flag;
			// R19 receive request
			rx_irq <= irq_gate & peripheral_interrupt_enable_reg[`AUS_INT_RX] & rx_avail_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read path
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= `AUS_ZERO_RESET;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`AUS_ADDR_BAUD_CTL: begin
					reg_rdata <= baud_control_reg;
					reg_rdata[`AUS_BC_RX_IDLE] <= (rx_state_reg == AUS_RX_HUNT);
				end
				`AUS_ADDR_RX_CTL:   reg_rdata <= {receive_status_control_reg[7:3],
					top_framing_error_status, overrun_reg, top_ninth};
				`AUS_ADDR_BRG_LO:   reg_rdata <= baud_divisor_low_reg;
				`AUS_ADDR_BRG_HI:   reg_rdata <= baud_divisor_high_reg;
				`AUS_ADDR_TX_CTL: begin
					reg_rdata <= transmit_status_control_reg;
					reg_rdata[`AUS_TX_EMPTY] <= ~tx_busy_reg;
				end
				`AUS_ADDR_RX_DATA:  reg_rdata <= (count_reg != 2'h0) ?
					fifo_data[rd_ptr_reg] : `AUS_ZERO_RESET;
				`AUS_ADDR_INT_FLAG: begin
					reg_rdata <= `AUS_ZERO_RESET;
					reg_rdata[`AUS_INT_RX] <= rx_avail_flag;
					reg_rdata[`AUS_INT_TX] <= tx_empty_flag;
				end
				`AUS_ADDR_INT_EN:   reg_rdata <= peripheral_interrupt_enable_reg;
				`AUS_ADDR_CORE_INT: reg_rdata <= core_interrupt_control_reg;
				default:            reg_rdata <= `AUS_ZERO_RESET;
			endcase
		end
	end
endmodule : aus_core
`default_nettype wire

// ==== dv/aus_core_props.sv ====
// port-level assertions for the async serial port
`timescale 1ns/1ps
`default_nettype none
`include "aus_regs.svh"
module aus_core_props
	import aus_pkg::*;
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       receive_line_pin,
	input wire logic       tx_pin_out,
	input wire logic       tx_pin_oe,
	input wire logic       tx_irq,
	input wire logic       rx_irq
);
	logic       transmitter_enable_reg, sync_reg, pe_reg, continuous_receive_enable_reg, pol_reg;
	logic       transmit_interrupt_enable_reg, receive_interrupt_enable_reg, gp_reg;
	logic [8:0] idle_reg;
	logic       oe_exp, rx_en, gate_tx, gate_rx;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	assign oe_exp  = pe_reg && !sync_reg;
	assign rx_en   = pe_reg && continuous_receive_enable_reg && !sync_reg;
	assign gate_tx = gp_reg && transmit_interrupt_enable_reg;
	assign gate_rx = gp_reg && receive_interrupt_enable_reg;
	////////////////////////////////////////////////////////////////
	// shadow of written control bits
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			{transmitter_enable_reg, sync_reg, pe_reg, continuous_receive_enable_reg, pol_reg} <= 5'h00;
			{transmit_interrupt_enable_reg, receive_interrupt_enable_reg, gp_reg} <= 3'h0;
		end else if (reg_wr) begin
			case (reg_addr)
			`AUS_ADDR_TX_CTL: {transmitter_enable_reg, sync_reg} <= reg_wdata[5:4];
			`AUS_ADDR_RX_CTL: {pe_reg, continuous_receive_enable_reg} <= {reg_wdata[7], reg_wdata[4]};
			`AUS_ADDR_BAUD_CTL: pol_reg <= reg_wdata[4];
			`AUS_ADDR_INT_EN: {receive_interrupt_enable_reg, transmit_interrupt_enable_reg} <= reg_wdata[5:4];
			`AUS_ADDR_CORE_INT: gp_reg <= reg_wdata[7] && reg_wdata[6];
			default: ;
			endcase
		end
	end
	// length of the current high run on the transmit line
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			idle_reg <= 9'h000;
		else if (!tx_pin_out)
			idle_reg <= 9'h000;
		else if (idle_reg != 9'h154)
			idle_reg <= idle_reg + 9'h001;
	end
	////////////////////////////////////////////////////////////////
	chk_oe_rise: assert property ($rose(oe_exp) |-> ##[0:2] tx_pin_oe)
		else $error("output enable missing after port enable");
	chk_tx_gate: assert property (!gate_tx && !$past(gate_tx) |-> !tx_irq)
		else $error("transmit interrupt without enables");
	chk_rx_gate: assert property (!gate_rx && !$past(gate_rx) |-> !rx_irq)
		else $error("receive interrupt without enables");
	chk_transmitter_enable_flag: assert property (reg_wr && reg_addr == `AUS_ADDR_TX_CTL && reg_wdata[5]
		&& !reg_wdata[4] && !transmitter_enable_reg && pe_reg && gate_tx |-> ##[1:4] tx_irq)
		else $error("transmit empty not raised on enable");
	chk_start_bit: assert property (reg_wr && reg_addr == `AUS_ADDR_TX_DATA && transmitter_enable_reg
		&& oe_exp && !pol_reg && idle_reg == 9'h154 |-> ##[1:4] !tx_pin_out)
		else $error("start bit late after data write");
	chk_idle_mark: assert property (!transmitter_enable_reg && !$past(transmitter_enable_reg) && !$past(transmitter_enable_reg, 2)
		&& !pol_reg && !$past(pol_reg) && !$past(pol_reg, 2) |-> tx_pin_out)
		else $error("idle transmit line not high");
	chk_idle_invert: assert property (!transmitter_enable_reg && !$past(transmitter_enable_reg) && !$past(transmitter_enable_reg, 2)
		&& oe_exp && $past(oe_exp, 2) && pol_reg && $past(pol_reg) |-> !tx_pin_out)
		else $error("inverted idle line not low");
	chk_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
		else $error("read data changed without a read");
	chk_framing_error_status_clear: assert property (reg_rd && reg_addr == `AUS_ADDR_RX_CTL && !pe_reg
		&& !$past(pe_reg) |=> !reg_rdata[2])
		else $error("framing status set with port disabled");
	chk_rxflag_off: assert property (reg_rd && reg_addr == `AUS_ADDR_INT_FLAG && !rx_en
		&& !$past(rx_en) |=> !reg_rdata[5])
		else $error("data available with receiver off");
endmodule : aus_core_props
bind aus_core aus_core_props i_aus_core_props (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.receive_line_pin(receive_line_pin), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
	.tx_irq(tx_irq), .rx_irq(rx_irq));
`default_nettype wire

// ==== dv/aus_remote.sv ====
// far serial station: frames into the receiver, decodes the transmit line
`timescale 1ns/1ps
`default_nettype none
module aus_remote #(
	parameter int BT = 32
) (
	input  wire logic clk,
	input  wire logic seen_line,
	output var  logic drive_line
);
	logic [8:0] rxq[$];
	int         rx_bits = 8;
	initial drive_line = 1'b1;
	// start low, lsb first, stop, idle gap
	task automatic send(input logic [8:0] d, input int nb, input logic stop);
		drive_line <= 1'b0;
		repeat (BT) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			drive_line <= d[i];
			repeat (BT) @(posedge clk);
		end
		drive_line <= stop;
		repeat (BT) @(posedge clk);
		drive_line <= 1'b1;
		repeat (BT) @(posedge clk);
	endtask : send
	// low pulse shorter than half a bit
	task automatic glitch();
		drive_line <= 1'b0;
		repeat (4) @(posedge clk);
		drive_line <= 1'b1;
		repeat (2 * BT) @(posedge clk);
	endtask : glitch
	initial begin
		logic [8:0] d;
		forever begin
			@(negedge seen_line);
			repeat (BT / 2) @(posedge clk);
			if (!seen_line) begin
				d = 9'h000;
				for (int i = 0; i < rx_bits; i++) begin
					repeat (BT) @(posedge clk);
					d[i] = seen_line;
				end
				repeat (BT) @(posedge clk);
				rxq.push_back(d);
			end
		end
	end
endmodule : aus_remote
`default_nettype wire

// ==== dv/aus_core_bench.sv ====
// self-checking bench for the async serial port
`timescale 1ns/1ps
`default_nettype none
`include "aus_regs.svh"
module aus_core_bench
	import aus_pkg::*;
	;
	localparam int BT = 32;
	logic       clk, arst_n, reg_wr, reg_rd, rx_line;
	logic       tx_pin_out, tx_pin_oe, tx_irq, rx_irq;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [9:0] mq[$];
	logic [3:0] za[4] = '{4'h2, 4'h1, 4'h7, 4'hf};
	logic       ovr = 1'b0, rx_on = 1'b0, ie_rx = 1'b0, adet = 1'b0;
	int         bad_count = 0, n_checks = 0, cyc = 0, nb = 8;
	int         seed = 32'h6bf60ddb;
	aus_byte_t  s, d;
	aus_core i_aus_core (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_line_pin(rx_line),
		.tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));
	aus_remote #(.BT(BT)) i_aus_remote (.clk(clk), .seen_line(tx_pin_out), .drive_line(rx_line));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, output aus_byte_t v);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		v = reg_rdata;
	endtask : rd
	task automatic rx(input logic [8:0] v, input logic stop);
		i_aus_remote.send(v, nb, stop);
		if (rx_on && !ovr && (!adet || v[8])) begin
			if (mq.size() == 2)
				ovr = 1'b1;
			else
				mq.push_back({!stop, nb == 9 ? v[8] : 1'b0, v[7:0]});
		end
	endtask : rx
	task automatic getc();
		logic [9:0] e;
		e = mq.size() ? mq[0] : 10'h000;
		rd(`AUS_ADDR_INT_FLAG, s);
		chk("rx_avail", s[5], rx_on && mq.size() != 0);
		chk("rx_irq", rx_irq, ie_rx && rx_on && mq.size() != 0);
		rd(`AUS_ADDR_RX_CTL, s);
		chk("overrun", s[1], ovr);
		if (mq.size() != 0) begin
			chk("framing_error_status", s[2], e[9]);
			if (nb == 9)
				chk("ninth", s[0], e[8]);
			rd(`AUS_ADDR_RX_DATA, s);
			chk("rx_data", s, e[7:0]);
			void'(mq.pop_front());
		end
	endtask : getc
	////////////////////////////////////////////////////////////////
	initial begin
		arst_n    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(`AUS_ADDR_TX_CTL, s);
		chk("tx_ctl_reset", s, `AUS_TX_CTL_RESET);
		rd(`AUS_ADDR_BAUD_CTL, s);
		chk("baud_ctl_reset", s, 8'h40);
		for (int i = 0; i < 4; i++) begin
			rd(za[i], s);
			chk("zero_reset", s, `AUS_ZERO_RESET);
		end
		wr(`AUS_ADDR_BRG_LO, 8'h01);
		wr(`AUS_ADDR_TX_CTL, 8'h04);
		wr(`AUS_ADDR_RX_CTL, 8'h90);
		rx_on = 1'b1;
		wr(`AUS_ADDR_CORE_INT, 8'hc0);
		wr(`AUS_ADDR_INT_EN, 8'h10);
		wr(`AUS_ADDR_BAUD_CTL, 8'h10);
		repeat (3) @(posedge clk);
		#1 chk("idle_inverted", tx_pin_out, 1'b0);
		wr(`AUS_ADDR_BAUD_CTL, 8'h08);
		repeat (3) @(posedge clk);
		#1 chk("idle_mark", tx_pin_out, 1'b1);
		wr(`AUS_ADDR_TX_CTL, 8'h24);
		rd(`AUS_ADDR_INT_FLAG, s);
		chk("tx_empty", s[4], 1'b1);
		chk("tx_irq_on", tx_irq, 1'b1);
		rd(`AUS_ADDR_TX_CTL, s);
		chk("tx_ctl", s, 8'h26);
		for (int k = 0; k < 4; k++) begin
			d = 8'($random(seed));
			i_aus_remote.rx_bits = 8 + k % 2;
			wr(`AUS_ADDR_TX_CTL, {1'b0, k[0], 5'h12, k[1]});
			wr(`AUS_ADDR_TX_DATA, d);
			for (int w = 0; w < 500 && i_aus_remote.rxq.size() == 0; w++)
				@(posedge clk);
			chk("tx_frame", i_aus_remote.rxq.pop_front(), {k[0] & k[1], d});
			repeat (360) @(posedge clk);
		end
		wr(`AUS_ADDR_INT_EN, 8'h20);
		ie_rx = 1'b1;
		@(posedge clk);
		#1 chk("tx_irq_off", tx_irq, 1'b0);
		for (int k = 0; k < 2; k++) begin
			d = 8'($random(seed));
			rx({1'b0, d}, k[0]);
		end
		for (int k = 0; k < 3; k++)
			getc();
		wr(`AUS_ADDR_RX_CTL, 8'hd8);
		adet = 1'b1;
		nb = 9;
		rx(9'h0a5, 1'b1);
		rx(9'h15a, 1'b1);
		getc();
		getc();
		wr(`AUS_ADDR_RX_CTL, 8'hd0);
		adet = 1'b0;
		rx(9'h0c3, 1'b1);
		getc();
		wr(`AUS_ADDR_RX_CTL, 8'h90);
		nb = 8;
		i_aus_remote.glitch();
		getc();
		for (int k = 0; k < 4; k++) begin
			d = 8'($random(seed));
			rx({1'b0, d}, 1'b1);
		end
		for (int k = 0; k < 3; k++)
			getc();
		wr(`AUS_ADDR_RX_CTL, 8'h80);
		rx_on = 1'b0;
		ovr = 1'b0;
		getc();
		wr(`AUS_ADDR_RX_CTL, 8'h90);
		rx_on = 1'b1;
		rx({1'b0, 8'h3c}, 1'b0);
		wr(`AUS_ADDR_RX_CTL, 8'h80);
		rx_on = 1'b0;
		getc();
		wr(`AUS_ADDR_RX_CTL, 8'h90);
		rx_on = 1'b1;
		rx({1'b0, 8'h81}, 1'b0);
		wr(`AUS_ADDR_RX_CTL, 8'h10);
		mq.delete();
		rd(`AUS_ADDR_RX_CTL, s);
		chk("framing_error_status_cleared", s[2], 1'b0);
		results();
	end
endmodule : aus_core_bench
`default_nettype wire
